// >>> dv/dpg_ctl_model.sv
/* channel controller model: middle byte then one transfer.
   assumes go is a one-cycle pulse from the bench. */
`default_nettype none
module dpg_ctl_model
  import dpg_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic go,
  input wire logic [2:0] chan,
  input wire logic [15:0] addr,
  output dpg_dma_t dma,
  output logic mid_strobe,
  output logic [7:0] mid_dbus
);
  logic go_q;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) go_q <= 1'b0;
    else go_q <= go;
  end
  // strobe at start of operation, then the transfer
  assign mid_strobe = go;
  // released bus shows the inverse, never a stale byte
  assign mid_dbus = go ? addr[15:8] : ~addr[15:8];
  assign dma = '{go_q, chan, go_q ? addr[7:0] : ~addr[7:0]};
endmodule // dpg_ctl_model
`default_nettype wire

// >>> dv/dpg_page_gen_monitor.sv
/* checks on dpg_page_gen ports.
   assumes the bind below reaches every instance. */
`default_nettype none
module dpg_page_gen_monitor
  import dpg_pkg::*;
#(parameter int unsigned NUM_LOC = DPG_NUM_LOC)
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire dpg_io_req_t io_req,
  input wire logic io_hit,
  input wire logic [7:0] io_rdata_q,
  input wire dpg_dma_t dma,
  input wire logic mid_strobe,
  input wire logic [7:0] mid_dbus,
  input wire dpg_addr_t addr_q,
  input wire logic ad_oe_q,
  input wire logic sbhe_oe
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_hit_decode: assert property (io_hit == (io_req.addr[15:4] == 12'h008))
    else $error("io window decode wrong");
  a_rd_hold: assert property (!(io_req.rd && io_hit) |=> $stable(io_rdata_q))
    else $error("read data moved");
  a_oe_delay: assert property (ad_oe_q == $past(dma.active))
    else $error("address enable late");
  a_sbhe_oe: assert property (sbhe_oe == ad_oe_q)
    else $error("byte high enable not driven");
  a_top_zero: assert property (addr_q.ad[31:24] == 8'h00)
    else $error("upper address not zero");
  a_la_match: assert property (addr_q.la == addr_q.ad[23:0])
    else $error("slot address differs");
  a_byte_low: assert property (dma.active && !dma.chan[2] |=>
    addr_q.ad[7:0] == $past(dma.low) && addr_q.sbhe_n == !addr_q.ad[0])
    else $error("byte low map wrong");
  a_word_low: assert property (dma.active && dma.chan[2] |=>
    addr_q.ad[8:0] == {$past(dma.low), 1'b0} && !addr_q.sbhe_n)
    else $error("word low map wrong");
  a_mid_map: assert property (mid_strobe ##1 (dma.active && !dma.chan[2]) |=>
    addr_q.ad[15:8] == $past(mid_dbus, 2))
    else $error("middle byte wrong");
endmodule // dpg_page_gen_monitor
bind dpg_page_gen dpg_page_gen_monitor #(.NUM_LOC(NUM_LOC)) u_mon (.mclk(mclk),
  .rst_n(rst_n), .io_req(io_req), .io_hit(io_hit), .io_rdata_q(io_rdata_q), .dma(dma),
  .mid_strobe(mid_strobe), .mid_dbus(mid_dbus), .addr_q(addr_q), .ad_oe_q(ad_oe_q),
  .sbhe_oe(sbhe_oe));
`default_nettype wire

// >>> dv/tb_dpg_page_gen.sv
/* self-checking bench for dpg_page_gen.
   assumes the package, model and checker are compiled first. */
`default_nettype none
module tb_dpg_page_gen import dpg_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 0, rst_n = 0, go = 0, io_hit, ad_oe_q, sbhe_oe;
  logic [2:0] chan = 0;
  logic [15:0] a = 0;
  logic [7:0] io_rdata_q, mid_dbus;
  logic [31:0] exp;
  logic mid_strobe;
  dpg_io_req_t io_req = '0;
  dpg_dma_t dma;
  dpg_addr_t addr_q;
  int err_count = 0, checks = 0;
  logic [7:0] pa [8] = '{8'h87, 8'h83, 8'h81, 8'h82, 8'h8f, 8'h8b, 8'h89, 8'h8a};
  logic [7:0] pv [8];
  always #12.5 mclk = ~mclk;
  dpg_page_gen u_dut (.mclk(mclk), .rst_n(rst_n), .io_req(io_req), .io_hit(io_hit),
    .io_rdata_q(io_rdata_q), .dma(dma), .mid_strobe(mid_strobe), .mid_dbus(mid_dbus),
    .addr_q(addr_q), .ad_oe_q(ad_oe_q), .sbhe_oe(sbhe_oe));
  dpg_ctl_model u_ctl (.mclk(mclk), .rst_n(rst_n), .go(go), .chan(chan), .addr(a),
    .dma(dma), .mid_strobe(mid_strobe), .mid_dbus(mid_dbus));
  ////////////////////////////////////////////////////////////////////////////////
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      err_count++;
      $display("wrong value %s exp %h seen %h", n, e, s);
    end
  endtask
  task io(input logic w, input logic [15:0] ad, input logic [7:0] d);
    @(posedge mclk) io_req <= '{w, !w, ad, d};
    @(posedge mclk) io_req <= '0;
    #1;
  endtask
  task summarize;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #100us;
    err_count++;
    summarize();
  end
  initial begin
    repeat (12) @(posedge mclk);
    rst_n <= 1;
    for (int c = 0; c < 8; c++) begin
      pv[c] = 8'(8'h30 + 37 * c);
      io(1, {8'h00, pa[c]}, pv[c]);
    end
    io(1, 16'h0080, 8'h5a);
    io(1, 16'h0090, 8'hc3);
    for (int c = 0; c < 8; c++) begin
      io(0, {8'h00, pa[c]}, 8'h00);
      chk("page", {24'h0, io_rdata_q}, {24'h0, pv[c]});
    end
    io(0, 16'h0080, 8'h00);
    chk("plain", {24'h0, io_rdata_q}, 32'h5a);
    io(0, 16'h0090, 8'h00);
    chk("outside", {24'h0, io_rdata_q}, 32'h5a);
    for (int c = 0; c < 8; c++) begin
      @(posedge mclk) begin
        go <= 1;
        chan <= 3'(c);
        a <= {8'(8'h40 + c), 8'(8'hf0 + c)}; // word channels take the address shifted up one bit
      end
      @(posedge mclk) go <= 0;
      @(posedge mclk) #1;
      exp = c < 4 ? {8'h00, pv[c], a} : {8'h00, pv[c][7:1], a, 1'b0};
      chk("ad", addr_q.ad, exp);
      chk("la", {8'h00, addr_q.la}, {8'h00, exp[23:0]});
      chk("sbhe", {31'h0, addr_q.sbhe_n}, {31'h0, c < 4 && !a[0]});
      chk("oe", {30'h0, ad_oe_q, sbhe_oe}, 32'h3);
    end
    summarize();
  end
endmodule // tb_dpg_page_gen
`default_nettype wire

// >>> logic/dpg_mid_latch.sv
/*
  middle address latch: one byte captured from the internal data bus on the
  controller's address strobe. assumes the strobe is a single-cycle pulse in
  first_transfer_state, synchronous to mclk.
*/
`default_nettype none
module dpg_mid_latch
  import dpg_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic strobe,
  input wire logic [7:0] dbus,
  output logic [7:0] mid_q
);
  //////////////////////////////////////////////////////////////////////////
  // no software path in: strobe is the only load
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mid_q <= DPG_MID_RST;
    end else if (strobe) begin
      mid_q <= dbus;
    end
  end
endmodule // dpg_mid_latch
`default_nettype wire

// >>> logic/dpg_page_gen.sv
/*
  dma page address generator: 32 byte page store, low 16 bytes on i/o 080h-08fh, and
  assembly of host and slot bus dma addresses.
  assumes the channel controller supplies low byte, channel and middle-byte strobe,
  and the host bus gives one-cycle read/write strobes.
*/
`default_nettype none
module dpg_page_gen
  import dpg_pkg::*;
#(
  parameter int unsigned NUM_LOC = DPG_NUM_LOC
)
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire dpg_io_req_t io_req,
  output logic io_hit,
  output logic [7:0] io_rdata_q,
  input wire dpg_dma_t dma,
  input wire logic mid_strobe,
  input wire logic [7:0] mid_dbus,
  output dpg_addr_t addr_q,
  output logic ad_oe_q,
  output logic sbhe_oe
);
  // the channel map and fold below assume exactly this many locations
  if (NUM_LOC != DPG_NUM_LOC) begin : g_bad_size
    $error("dpg_page_gen: store must hold exactly 32 locations");
  end

  //////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [DPG_LOC_AW-1:0] loc_of_io(input logic [15:0] a);
    // 16 i/o bytes fold onto the low half; channel pages read the low half too, so the upper half goes unused
    loc_of_io = {1'b0, a[3:0]};
  endfunction

  function automatic logic [7:0] chan_io(input logic [2:0] c);
    unique case (c)
      3'h0: chan_io = DPG_CHAN0_PAGE;
      3'h1: chan_io = DPG_CHAN1_PAGE;
      3'h2: chan_io = DPG_CHAN2_PAGE;
      3'h3: chan_io = DPG_CHAN3_PAGE;
      3'h4: chan_io = DPG_CHAN4_PAGE;
      3'h5: chan_io = DPG_CHAN5_PAGE;
      3'h6: chan_io = DPG_CHAN6_PAGE;
      3'h7: chan_io = DPG_CHAN7_PAGE;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // i/o decode and page store
  logic [7:0] page_mem [NUM_LOC];
  logic [DPG_LOC_AW-1:0] io_loc;

  assign io_hit = (io_req.addr >= DPG_WIN_BASE) && (io_req.addr <= DPG_WIN_LAST);
  assign io_loc = loc_of_io(io_req.addr);

  // every window byte is storage; channel pages are simply its mapped bytes
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_LOC; i++) begin
        page_mem[i] <= DPG_PAGE_RST;
      end
    end else if (io_req.wr && io_hit) begin
      page_mem[io_loc] <= io_req.wdata;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      io_rdata_q <= 8'h00;
    end else if (io_req.rd && io_hit) begin
      io_rdata_q <= page_mem[io_loc];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // middle byte latch
  logic [7:0] mid_q;

  dpg_mid_latch u_mid (
    .mclk(mclk),
    .rst_n(rst_n),
    .strobe(mid_strobe),
    .dbus(mid_dbus),
    .mid_q(mid_q)
  );

  //////////////////////////////////////////////////////////////////////////
  // address assembly
  logic [7:0] page;
  logic word_chan;
  dpg_addr_t addr_d;

  // channel 4 is the cascade; it is treated as word-wide like its controller
  assign word_chan = dma.chan[2];
  assign page = page_mem[loc_of_io({8'h00, chan_io(dma.chan)})];

  always_comb begin
    addr_d = '0;
    addr_d.ad[31:24] = 8'h00;
    if (word_chan) begin
      // page bit 0 dropped: wrap stays inside 128k, no carry into page
      addr_d.ad[23:17] = page[7:1];
      addr_d.ad[16:9] = mid_q;
      addr_d.ad[8:1] = dma.low;
      addr_d.la[23:17] = page[7:1];
      addr_d.la[16:9] = mid_q;
      addr_d.la[8:1] = dma.low;
      addr_d.la[0] = 1'b0;
      addr_d.sbhe_n = 1'b0;
    end else begin
      addr_d.ad[23:16] = page;
      addr_d.ad[15:8] = mid_q;
      addr_d.ad[7:0] = dma.low;
      addr_d.la[23:16] = page;
      addr_d.la[15:8] = mid_q;
      addr_d.la[7:0] = dma.low;
      addr_d.sbhe_n = ~dma.low[0];
    end
  end

  // registered so the buses see glitch-free values
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      addr_q <= '0;
      ad_oe_q <= 1'b0;
    end else begin
      addr_q <= dma.active ? addr_d : '0;
      ad_oe_q <= dma.active;
    end
  end

  assign sbhe_oe = ad_oe_q;
endmodule // dpg_page_gen
`default_nettype wire

// >>> logic/dpg_pkg.sv
/*
  package for the dma page address generator: i/o map, widths, strobe carriers.
  assumes the host bus decodes 16-bit i/o addresses and presents one byte per access.
*/
`default_nettype none
package dpg_pkg;
  localparam int unsigned DPG_NUM_LOC = 32;
  localparam int unsigned DPG_LOC_AW = 5;
  localparam logic [15:0] DPG_WIN_BASE = 16'h0080;
  localparam logic [15:0] DPG_WIN_LAST = 16'h008f;
  localparam logic [7:0] DPG_CHAN0_PAGE = 8'h87;
  localparam logic [7:0] DPG_CHAN1_PAGE = 8'h83;
  localparam logic [7:0] DPG_CHAN2_PAGE = 8'h81;
  localparam logic [7:0] DPG_CHAN3_PAGE = 8'h82;
  localparam logic [7:0] DPG_CHAN4_PAGE = 8'h8f;
  localparam logic [7:0] DPG_CHAN5_PAGE = 8'h8b;
  localparam logic [7:0] DPG_CHAN6_PAGE = 8'h89;
  localparam logic [7:0] DPG_CHAN7_PAGE = 8'h8a;
  localparam logic [7:0] DPG_PAGE_RST = 8'h00;
  localparam logic [7:0] DPG_MID_RST = 8'h00;
  localparam int unsigned DPG_BYTE_PAGE_KB = 64;
  localparam int unsigned DPG_WORD_PAGE_KB = 128;
  localparam int unsigned DPG_BYTE_BLOCK = 256;
  localparam int unsigned DPG_WORD_BLOCK = 512;
  localparam int unsigned DPG_WORD_SHIFT = 1;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } dpg_io_req_t;

  typedef struct packed {
    logic active;
    logic [2:0] chan;
    logic [7:0] low;
  } dpg_dma_t;

  typedef struct packed {
    logic [31:0] ad;
    logic [23:0] la;
    logic sbhe_n;
  } dpg_addr_t;
endpackage
`default_nettype wire
